/* verilog/tia_gain_defines.svh */
// Offsets, field positions, reset values and timing counts of the gain register.
`ifndef TIA_GAIN_DEFINES_SVH
`define TIA_GAIN_DEFINES_SVH
`define TIA_GAIN_ADDR       8'h55
`define TIA_GAIN_RESET      12'h000
`define TIA_GAIN_FIELD_MSB  11
`define SLOT_B_CH4_LSB      10
`define SLOT_B_CH3_LSB      8
`define SLOT_B_CH2_LSB      6
`define SLOT_A_CH4_LSB      4
`define SLOT_A_CH3_LSB      2
`define SLOT_A_CH2_LSB      0
`define SLOT_B_LSB          6
`define SLOT_A_LSB          0
`define GAIN_FIELD_W        2
`define GAIN_CH_COUNT       3
`define RESERVED_READ       4'h0
`define GAIN_LATENCY        2
`endif

/* verilog/tia_gain_pkg.sv */
// Types shared by the gain register and its slot selector.
package tia_gain_pkg;
	typedef logic [1:0]  gain_code_type;
	typedef logic [5:0]  slot_gains_type;
	typedef logic [11:0] gain_cfg_type;

	typedef struct packed {
		gain_cfg_type cfg_r;
		logic [15:0]  rdata_r;
		logic         rvalid_r;
	} reg_state_type;

	typedef struct packed {
		slot_gains_type gain_r;
	} mux_state_type;
endpackage

/* verilog/gain_slot_mux.sv */
// Per-slot selector of the effective amplifier gain codes for channels 2 to 4.
`include "tia_gain_defines.svh"

module gain_slot_mux (
	input  wire logic                        clk,
	input  wire logic                        rst_sync_n,
	input  wire logic                        ce,
	input  wire logic                        individual_enable,
	input  wire tia_gain_pkg::gain_code_type  common_gain,
	input  wire tia_gain_pkg::slot_gains_type fields,
	output tia_gain_pkg::slot_gains_type      gain_eff
);
	tia_gain_pkg::mux_state_type  st_r;
	tia_gain_pkg::mux_state_type  st_nxt;
	tia_gain_pkg::slot_gains_type pick;

	// With individual gain off the per-channel fields are ignored and every
	// channel follows the slot's shared gain code.
	genvar ch;
	generate
		for (ch = 0; ch < `GAIN_CH_COUNT; ch++) begin : g_ch
			assign pick[ch*`GAIN_FIELD_W +: `GAIN_FIELD_W] =
				individual_enable ?
				fields[ch*`GAIN_FIELD_W +: `GAIN_FIELD_W] :
				common_gain;
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		if (ce) begin
			st_nxt.gain_r = pick;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign gain_eff = st_r.gain_r;

	// The sampled reset joins each antecedent: at the releasing edge the
	// flops are still held although disable iff already reads it high.
	ind_fields_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && individual_enable) |=>
		gain_eff == $past(fields))
		else $error("individual gain fields not applied");

	shared_gain_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && !individual_enable) |=>
		gain_eff == {3{$past(common_gain)}})
		else $error("fields not ignored while individual gain is off");

	frozen_hold_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && !ce) |=> $stable(gain_eff))
		else $error("gain changed while clock enable was low");

	ind_toggle_c: cover property (@(posedge clk) disable iff (!rst_sync_n)
		ce && individual_enable ##1 ce && !individual_enable);
endmodule

/* verilog/tia_gain_select_register.sv */
// Channel 2 to 4 amplifier gain register for time slots A and B.
`include "tia_gain_defines.svh"

// Overview of operation
// - Bits 11:10: slot B ch4 gain, 200/100/50/25 kohm, if B individual on.
// - Bits 9:8: slot B ch3 gain, same four-code scale, if B individual on.
// - Bits 7:6: slot B ch2 gain, 200 kohm at code 0 halving per step.
// - Bits 5:4: slot A ch4 gain, applied only while A individual is on.
// - Bits 3:2: slot A ch3 gain, applied only while A individual is on.
// - Bits 1:0: slot A ch2 gain, applied only while A individual is on.
// - Slot A enable set: ch2 to ch4 take these fields; clear: ignored.
module tia_gain_select_register (
	input  wire logic                        clk,
	input  wire logic                        rstn,
	input  wire logic                        ce,
	input  wire logic [7:0]                  reg_addr,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	input  wire logic [15:0]                 reg_wdata,
	output logic [15:0]                      reg_rdata,
	output logic                             reg_rvalid,
	input  wire logic                        slot_a_individual_gain_enable,
	input  wire logic                        slot_b_individual_gain_enable,
	input  wire tia_gain_pkg::gain_code_type  slot_a_common_gain,
	input  wire tia_gain_pkg::gain_code_type  slot_b_common_gain,
	output tia_gain_pkg::slot_gains_type      slot_a_gain,
	output tia_gain_pkg::slot_gains_type      slot_b_gain
);
	tia_gain_pkg::reg_state_type  st_r;
	tia_gain_pkg::reg_state_type  st_nxt;
	tia_gain_pkg::gain_code_type  slot_b_ch4_gain;
	tia_gain_pkg::gain_code_type  slot_b_ch3_gain;
	tia_gain_pkg::gain_code_type  slot_b_ch2_gain;
	tia_gain_pkg::gain_code_type  slot_a_ch4_gain;
	tia_gain_pkg::gain_code_type  slot_a_ch3_gain;
	tia_gain_pkg::gain_code_type  slot_a_ch2_gain;
	tia_gain_pkg::slot_gains_type slot_a_fields;
	tia_gain_pkg::slot_gains_type slot_b_fields;
	logic [1:0]                   rst_pipe_r;
	logic                         rst_sync_n;
	logic                         hit;

	// The reset synchroniser ignores ce so that a frozen block still
	// leaves reset cleanly once the enable returns.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_pipe_r <= 2'h0;
		end else begin
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe_r[1];

	assign hit = (reg_addr == `TIA_GAIN_ADDR);

	// Named views of the stored fields; each slot hands its three codes to
	// its selector with channel 2 in the low bits.
	assign slot_b_ch4_gain =
		st_r.cfg_r[`SLOT_B_CH4_LSB +: `GAIN_FIELD_W];
	assign slot_b_ch3_gain =
		st_r.cfg_r[`SLOT_B_CH3_LSB +: `GAIN_FIELD_W];
	assign slot_b_ch2_gain =
		st_r.cfg_r[`SLOT_B_CH2_LSB +: `GAIN_FIELD_W];
	assign slot_a_ch4_gain =
		st_r.cfg_r[`SLOT_A_CH4_LSB +: `GAIN_FIELD_W];
	assign slot_a_ch3_gain =
		st_r.cfg_r[`SLOT_A_CH3_LSB +: `GAIN_FIELD_W];
	assign slot_a_ch2_gain =
		st_r.cfg_r[`SLOT_A_CH2_LSB +: `GAIN_FIELD_W];
	assign slot_a_fields =
		{slot_a_ch4_gain, slot_a_ch3_gain, slot_a_ch2_gain};
	assign slot_b_fields =
		{slot_b_ch4_gain, slot_b_ch3_gain, slot_b_ch2_gain};

	always_comb begin
		st_nxt = st_r;
		if (ce) begin
			st_nxt.rvalid_r = reg_rd && hit;
			if (reg_rd && hit) begin
				// A read in the same cycle as a write returns the old value.
				st_nxt.rdata_r = {`RESERVED_READ, st_r.cfg_r};
			end
			if (reg_wr && hit) begin
				// Reserved bits are not stored, so a stray one cannot stick.
				st_nxt.cfg_r = reg_wdata[`TIA_GAIN_FIELD_MSB:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_r.cfg_r    <= `TIA_GAIN_RESET;
			st_r.rdata_r  <= 16'h0000;
			st_r.rvalid_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata  = st_r.rdata_r;
	assign reg_rvalid = st_r.rvalid_r;

	gain_slot_mux u_slot_a (
		.clk               (clk),
		.rst_sync_n        (rst_sync_n),
		.ce                (ce),
		.individual_enable (slot_a_individual_gain_enable),
		.common_gain       (slot_a_common_gain),
		.fields            (slot_a_fields),
		.gain_eff          (slot_a_gain)
	);

	gain_slot_mux u_slot_b (
		.clk               (clk),
		.rst_sync_n        (rst_sync_n),
		.ce                (ce),
		.individual_enable (slot_b_individual_gain_enable),
		.common_gain       (slot_b_common_gain),
		.fields            (slot_b_fields),
		.gain_eff          (slot_b_gain)
	);

	// Antecedents also ask for the sampled reset to be high: at the edge
	// that releases it the logic is still held, while disable iff already
	// sees the new value.
	b_ch4_store_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && reg_wr && hit) |=>
		st_r.cfg_r[11:10] == $past(reg_wdata[11:10]))
		else $error("slot B channel 4 field not stored");

	b_ch4_path_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && reg_wr && hit &&
		slot_b_individual_gain_enable) ##1
		(ce && slot_b_individual_gain_enable) |=>
		slot_b_gain[5:4] == $past(reg_wdata[11:10], 2))
		else $error("slot B channel 4 gain not applied");

	b_ch3_path_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && reg_wr && hit &&
		slot_b_individual_gain_enable) ##1
		(ce && slot_b_individual_gain_enable) |=>
		slot_b_gain[3:2] == $past(reg_wdata[9:8], 2))
		else $error("slot B channel 3 gain not applied");

	b_ch2_path_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && reg_wr && hit &&
		slot_b_individual_gain_enable) ##1
		(ce && slot_b_individual_gain_enable) |=>
		slot_b_gain[1:0] == $past(reg_wdata[7:6], 2))
		else $error("slot B channel 2 gain not applied");

	a_ch4_path_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && reg_wr && hit &&
		slot_a_individual_gain_enable) ##1
		(ce && slot_a_individual_gain_enable) |=>
		slot_a_gain[5:4] == $past(reg_wdata[5:4], 2))
		else $error("slot A channel 4 gain not applied");

	a_ch3_path_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && reg_wr && hit &&
		slot_a_individual_gain_enable) ##1
		(ce && slot_a_individual_gain_enable) |=>
		slot_a_gain[3:2] == $past(reg_wdata[3:2], 2))
		else $error("slot A channel 3 gain not applied");

	a_fields_path_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && reg_wr && hit &&
		slot_a_individual_gain_enable) ##1
		(ce && slot_a_individual_gain_enable) |=>
		slot_a_gain == $past(reg_wdata[5:0], 2))
		else $error("slot A gains not applied");

	a_ignored_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && !slot_a_individual_gain_enable) |=>
		slot_a_gain == {3{$past(slot_a_common_gain)}})
		else $error("slot A fields used while individual gain is off");

	readback_word_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && reg_rd && hit) |=>
		reg_rvalid && reg_rdata == {4'h0, $past(st_r.cfg_r)})
		else $error("read back value wrong");

	rvalid_pulse_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && !(reg_rd && hit)) |=> !reg_rvalid)
		else $error("read valid without a read of this register");

	read_no_side_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && reg_rd && !reg_wr) |=> $stable(st_r.cfg_r))
		else $error("a read changed the register");

	// A frozen block must keep even a pending read answer on its pins.
	freeze_cfg_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && !ce) |=> $stable(st_r.cfg_r) &&
		$stable(reg_rdata) && $stable(reg_rvalid))
		else $error("register state changed while clock enable was low");

	reset_zero_a: assert property (@(posedge clk)
		$rose(rst_sync_n) |-> st_r.cfg_r == 12'h000 && !reg_rvalid &&
		reg_rdata == 16'h0000 && slot_a_gain == 6'h00 &&
		slot_b_gain == 6'h00)
		else $error("register not zero after reset");

	miss_quiet_a: assert property (@(posedge clk)
		disable iff (!rst_sync_n)
		(rst_sync_n && ce && reg_wr && !hit) |=> $stable(st_r.cfg_r))
		else $error("write to another address changed the register");

	write_c: cover property (@(posedge clk) disable iff (!rst_sync_n)
		ce && reg_wr && hit && reg_wdata[11:0] != 12'h000);
	read_c: cover property (@(posedge clk) disable iff (!rst_sync_n)
		ce && reg_rd && hit ##1 reg_rvalid && reg_rdata != 16'h0000);
	freeze_c: cover property (@(posedge clk) disable iff (!rst_sync_n)
		!ce && reg_wr && hit);
	wr_then_rd_c: cover property (@(posedge clk) disable iff (!rst_sync_n)
		ce && reg_wr && hit ##2 ce && reg_rd && hit);
endmodule

/* tb/test_tia_gain_select_register.sv */
// Self-checking bench for the channel 2 to 4 amplifier gain register.
module test_tia_gain_select_register;
	timeunit 1ns;
	timeprecision 1ps;

	logic                         clk       = 1'b0;
	logic                         rstn      = 1'b0;
	logic                         ce        = 1'b1;
	logic [7:0]                   reg_addr  = 8'h00;
	logic                         reg_wr    = 1'b0;
	logic                         reg_rd    = 1'b0;
	logic [15:0]                  reg_wdata = 16'h0000;
	logic                         en_a      = 1'b1;
	logic                         en_b      = 1'b1;
	tia_gain_pkg::gain_code_type  cg_a      = 2'h0;
	tia_gain_pkg::gain_code_type  cg_b      = 2'h0;
	logic [15:0]                  reg_rdata;
	logic                         reg_rvalid;
	tia_gain_pkg::slot_gains_type slot_a_gain;
	tia_gain_pkg::slot_gains_type slot_b_gain;
	int                           mismatches  = 0;
	int                           comparisons = 0;
	logic [15:0]                  tbl [6] = '{16'h0000, 16'h0555, 16'h0aaa,
		16'h0fff, 16'h09e4, 16'h061b};

	tia_gain_select_register tia_gain_select_register_i (
		.clk                           (clk),
		.rstn                          (rstn),
		.ce                            (ce),
		.reg_addr                      (reg_addr),
		.reg_wr                        (reg_wr),
		.reg_rd                        (reg_rd),
		.reg_wdata                     (reg_wdata),
		.reg_rdata                     (reg_rdata),
		.reg_rvalid                    (reg_rvalid),
		.slot_a_individual_gain_enable (en_a),
		.slot_b_individual_gain_enable (en_b),
		.slot_a_common_gain            (cg_a),
		.slot_b_common_gain            (cg_b),
		.slot_a_gain                   (slot_a_gain),
		.slot_b_gain                   (slot_b_gain)
	);

	always #2 clk = ~clk;

	task automatic close_out();
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// The synchroniser needs two edges after release, so four are given.
	task automatic do_reset();
		rstn = 1'b0;
		repeat (4) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (4) @(posedge clk);
		#1;
	endtask

	// The trailing edge keeps the strobe from being raised again at once.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1 reg_wr = 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp,
		input logic hit);
		logic        ok;
		logic [15:0] d;
		ok = 1'b0;
		d = 16'h0000;
		reg_addr = a;
		reg_rd = 1'b1;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			#1 reg_rd = 1'b0;
			if (reg_rvalid === 1'b1 && ok === 1'b0) begin
				ok = 1'b1;
				d = reg_rdata;
			end
		end
		check("reg_rvalid", {15'h0000, ok}, {15'h0000, hit});
		if (hit)
			check("reg_rdata", d, exp);
	endtask

	task automatic gchk(input logic [5:0] ea, input logic [5:0] eb);
		repeat (3) @(posedge clk);
		#1;
		check("slot_a_gain", {10'h000, slot_a_gain}, {10'h000, ea});
		check("slot_b_gain", {10'h000, slot_b_gain}, {10'h000, eb});
	endtask

	initial begin
		#20000;
		mismatches++;
		close_out();
	end

	initial begin
		do_reset();
		rd_chk(8'h55, 16'h0000, 1'b1);
		gchk(6'h00, 6'h00);
		foreach (tbl[i]) begin
			wr(8'h55, tbl[i]);
			rd_chk(8'h55, {4'h0, tbl[i][11:0]}, 1'b1);
			gchk(tbl[i][5:0], tbl[i][11:6]);
		end
		en_a = 1'b0;
		en_b = 1'b0;
		cg_a = 2'h2;
		cg_b = 2'h1;
		gchk(6'h2a, 6'h15);
		en_b = 1'b1;
		gchk(6'h2a, 6'h18);
		en_a = 1'b1;
		en_b = 1'b0;
		gchk(6'h1b, 6'h15);
		// Neighbouring address and a frozen clock enable must leave it alone.
		wr(8'h54, 16'h0fff);
		rd_chk(8'h54, 16'h0000, 1'b0);
		ce = 1'b0;
		wr(8'h55, 16'h0000);
		ce = 1'b1;
		rd_chk(8'h55, 16'h061b, 1'b1);
		do_reset();
		rd_chk(8'h55, 16'h0000, 1'b1);
		gchk(6'h00, 6'h15);
		close_out();
	end
endmodule
